/* eiei_top.sv */
// External interrupt and wake event input stage
`timescale 1ns/1ps

module eiei_top (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_n_i,
  input  wire eiei_pkg::eiei_pins_t         pins_i,
  input  wire eiei_pkg::eiei_route_t        route_i,
  input  wire logic [eiei_pkg::PORT_W-1:0]  general_port_bits_i,
  input  wire logic [eiei_pkg::PORT_W-1:0]  port_drive_i,
  input  wire logic [eiei_pkg::PORT_W-1:0]  port_irq_en_i,
  input  wire logic                         edge_one_clr_i,
  input  wire logic                         rise_clr_i,
  input  wire logic                         low_power_i,
  output logic [eiei_pkg::PORT_W-1:0]       general_port_bits_oe_n_o,
  output logic [eiei_pkg::PORT_W-1:0]       port_level_o,
  output logic [eiei_pkg::IOC_W-1:0]        io_control_register_o,
  output logic                              normal_irq_o,
  output logic                              fast_interrupt_request_o,
  output logic                              wake_o
);

  // ****************************************
  // Helpers
  // ****************************************
  // High-to-low step between two synchroniser stages
  function automatic logic fell(input logic now, input logic was);
    fell = was & ~now;
  endfunction

  // Low-to-high step between two synchroniser stages
  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  // Share of a steerable request that goes to the wanted class
  function automatic logic steer(input logic act,
                                 input logic to_fast,
                                 input logic want_fast);
    steer = act & (to_fast == want_fast);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Stage one is read only by stage two; edges use stages two and three
  eiei_pkg::eiei_pins_t              s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

  always_comb begin
    s1_d = pins_i;
    s2_d = s1_q;
    s3_d = s2_q;
    // Reset loads idle levels so release shows no false edge
    if (!rst_n_i) begin
      s1_d = eiei_pkg::PIN_IDLE;
      s2_d = eiei_pkg::PIN_IDLE;
      s3_d = eiei_pkg::PIN_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
    s3_q <= s3_d;
  end

  // ****************************************
  // Port synchronisers
  // ****************************************
  logic [eiei_pkg::PORT_W-1:0]       p1_q, p1_d, p2_q, p2_d;

  always_comb begin
    p1_d = general_port_bits_i;
    p2_d = p1_q;
    if (!rst_n_i) begin
      p1_d = eiei_pkg::PORT_RST;
      p2_d = eiei_pkg::PORT_RST;
    end
  end

  always_ff @(posedge core_clk_i) begin
    p1_q <= p1_d;
    p2_q <= p2_d;
  end

  // ****************************************
  // Edge request latches
  // ****************************************
  logic                              edge_one_q, edge_one_d;
  logic                              rise_q, rise_d;

  always_comb begin
    // Set beats clear so an edge in the clear cycle is kept
    edge_one_d = (edge_one_q & ~edge_one_clr_i)
               | fell(s2_q.edge_one_n, s3_q.edge_one_n);
    rise_d     = (rise_q & ~rise_clr_i)
               | rose(s2_q.rise, s3_q.rise);
    if (!rst_n_i) begin
      edge_one_d = 1'b0;
      rise_d     = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    edge_one_q <= edge_one_d;
    rise_q     <= rise_d;
  end

  // ****************************************
  // Level decode and request routing
  // ****************************************
  logic                              norm_q, norm_d;
  logic                              fast_q, fast_d;

  always_comb begin
    logic lvl_a;
    logic lvl_b;
    logic lvl_hi;
    logic st_hi;
    logic st_lo;
    logic st_lo2;
    logic port_any;
    // Active-low pins are inverted here; terms below are active high
    lvl_a    = ~s2_q.low_a_n;
    lvl_b    = ~s2_q.low_b_n;
    lvl_hi   = s2_q.level_hi;
    st_hi    = s2_q.steer_hi;
    st_lo    = ~s2_q.steer_lo_n;
    st_lo2   = ~s2_q.steer_lo2_n;
    // Port bits request on a low level, only where enabled
    port_any = |(~p2_q & port_irq_en_i);
    norm_d = edge_one_q | rise_q
           | lvl_a | lvl_b | lvl_hi
           | steer(st_hi, route_i.steer_hi_fast, 1'b0)
           | steer(st_lo, route_i.steer_lo_fast, 1'b0)
           | steer(st_lo2, route_i.steer_lo2_fast, 1'b0)
           | port_any;
    // The fast-only pin has no path into the normal request
    fast_d = s2_q.fast_only
           | steer(st_hi, route_i.steer_hi_fast, 1'b1)
           | steer(st_lo, route_i.steer_lo_fast, 1'b1)
           | steer(st_lo2, route_i.steer_lo2_fast, 1'b1);
    if (!rst_n_i) begin
      norm_d = 1'b0;
      fast_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    norm_q <= norm_d;
    fast_q <= fast_d;
  end

  // ****************************************
  // Wake events
  // ****************************************
  // Only a fresh fall wakes; a pin held low across entry does not
  logic                              wake_q, wake_d;

  always_comb begin
    logic ev;
    ev     = fell(s2_q.event_one_n, s3_q.event_one_n)
           | fell(s2_q.event_two_n, s3_q.event_two_n);
    wake_d = ev & low_power_i;
    if (!rst_n_i) begin
      wake_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    wake_q <= wake_d;
  end

  // ****************************************
  // Status word and port outputs
  // ****************************************
  logic [eiei_pkg::IOC_W-1:0]        ioc_q, ioc_d;
  logic [eiei_pkg::PORT_W-1:0]       oe_q, oe_d, lvl_q, lvl_d;

  always_comb begin
    ioc_d = eiei_pkg::IOC_RST;
    ioc_d[eiei_pkg::IOC_EDGE1_LVL] = s2_q.edge_one_n;
    // Open-drain pins feed only the status word, no request path
    ioc_d[eiei_pkg::IOC_OD_LO +: eiei_pkg::OD_W] = s2_q.od;
    ioc_d[eiei_pkg::IOC_EV1_LVL] = s2_q.event_one_n;
    ioc_d[eiei_pkg::IOC_EV2_LVL] = s2_q.event_two_n;
    // Open drain: enable low pulls the pin low
    oe_d  = port_drive_i;
    lvl_d = p2_q;
    if (!rst_n_i) begin
      ioc_d = eiei_pkg::IOC_RST;
      oe_d  = eiei_pkg::PORT_OE_RST;
      lvl_d = eiei_pkg::PORT_RST;
    end
  end

  always_ff @(posedge core_clk_i) begin
    ioc_q <= ioc_d;
    oe_q  <= oe_d;
    lvl_q <= lvl_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign normal_irq_o             = norm_q;
  assign fast_interrupt_request_o = fast_q;
  assign wake_o                   = wake_q;
  assign io_control_register_o    = ioc_q;
  assign general_port_bits_oe_n_o = oe_q;
  assign port_level_o             = lvl_q;

endmodule

/* eiei_pkg.sv */
// Constants and carrier types for the external interrupt input stage
package eiei_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned PORT_W = 8;
  localparam int unsigned OD_W   = 2;
  localparam int unsigned IOC_W  = 8;

  // ****************************************
  // Status word field positions
  // ****************************************
  localparam int unsigned IOC_EDGE1_LVL = 0;
  localparam int unsigned IOC_OD_LO     = 1;
  localparam int unsigned IOC_EV1_LVL   = 3;
  localparam int unsigned IOC_EV2_LVL   = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [IOC_W-1:0]  IOC_RST   = 8'h00;
  localparam logic [PORT_W-1:0] PORT_RST  = 8'hff;
  localparam logic [PORT_W-1:0] PORT_OE_RST = 8'hff;
  // Idle level of every pin after reset, so no false edge at release
  localparam logic [16:0] PIN_IDLE = 17'h1_66f0;

  // Pin group, raw as seen at the pins (active-low pins idle high)
  typedef struct packed {
    logic              edge_one_n;  // Falling-edge request
    logic              rise;        // Rising-edge request
    logic              low_a_n;     // Level, normal only
    logic              low_b_n;     // Level, normal only
    logic              level_hi;    // Level high, normal only
    logic              steer_hi;    // Level high, normal or fast
    logic              steer_lo_n;  // Level low, normal or fast
    logic              steer_lo2_n; // Level low, fast or normal
    logic              fast_only;   // Level high, fast only
    logic              event_one_n; // Wake event 1
    logic              event_two_n; // Wake event 2
    logic [OD_W-1:0]   od;          // Open-drain, never interrupts
    logic [3:0]        spare;       // Keeps width aligned, unused
  } eiei_pins_t;

  // Routing selects: high chooses the fast request
  typedef struct packed {
    logic steer_hi_fast;
    logic steer_lo_fast;
    logic steer_lo2_fast;
  } eiei_route_t;

endpackage

/* eiei_props.sv */
// Port-level assertions for the interrupt input stage
`timescale 1ns/1ps
module eiei_props (
  input wire logic                        core_clk_i,
  input wire logic                        rst_n_i,
  input wire eiei_pkg::eiei_pins_t        pins_i,
  input wire logic [eiei_pkg::PORT_W-1:0] general_port_bits_i,
  input wire logic [eiei_pkg::PORT_W-1:0] port_drive_i,
  input wire logic                        low_power_i,
  input wire logic [eiei_pkg::PORT_W-1:0] general_port_bits_oe_n_o,
  input wire logic [eiei_pkg::PORT_W-1:0] port_level_o,
  input wire logic [eiei_pkg::IOC_W-1:0]  io_control_register_o,
  input wire logic                        normal_irq_o,
  input wire logic                        fast_interrupt_request_o,
  input wire logic                        wake_o
);
  logic [2:0] up_q;
  logic [2:0] up_d;
  logic       ok;
  // Sync stages hold reset values for a few edges after release
  always_comb up_d = (up_q == 3'h4) ? up_q : up_q + 3'h1;
  always_ff @(posedge core_clk_i) up_q <= rst_n_i ? up_d : 3'h0;
  assign ok = (up_q == 3'h4);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_fall1;
    $past(pins_i.event_one_n, 4) && !$past(pins_i.event_one_n, 3);
  endsequence
  sequence s_fall2;
    $past(pins_i.event_two_n, 4) && !$past(pins_i.event_two_n, 3);
  endsequence
  property p_ioc_edge;
    ok |-> io_control_register_o[0] == $past(pins_i.edge_one_n, 3);
  endproperty
  property p_ioc_ev;
    ok |-> io_control_register_o[4:3] ==
      {$past(pins_i.event_two_n, 3), $past(pins_i.event_one_n, 3)};
  endproperty
  property p_ioc_zero;
    ok |-> io_control_register_o[7:5] == 3'h0;
  endproperty
  property p_oe;
    ok |-> general_port_bits_oe_n_o == $past(port_drive_i);
  endproperty
  property p_port;
    ok |-> port_level_o == $past(general_port_bits_i, 3);
  endproperty
  property p_fast;
    ok && fast_interrupt_request_o |-> $past(pins_i.fast_only, 3) ||
      $past(pins_i.steer_hi, 3) || !$past(pins_i.steer_lo_n, 3) ||
      !$past(pins_i.steer_lo2_n, 3);
  endproperty
  property p_wake_lp;
    wake_o |-> $past(low_power_i);
  endproperty
  property p_wake_src;
    ok && wake_o |-> s_fall1 or s_fall2;
  endproperty
  property p_wake_one;
    wake_o |=> !wake_o;
  endproperty
  property p_ioc_od;
    ok |-> io_control_register_o[2:1] == $past(pins_i.od, 3);
  endproperty
  property p_norm_lvl;
    ok && (!$past(pins_i.low_a_n, 3) || !$past(pins_i.low_b_n, 3) ||
      $past(pins_i.level_hi, 3)) |-> normal_irq_o;
  endproperty
  property p_fast_only;
    ok && $past(pins_i.fast_only, 3) |-> fast_interrupt_request_o;
  endproperty
  a_ioc_edge: assert property (p_ioc_edge)
    else $error("edge level");
  a_ioc_ev: assert property (p_ioc_ev)
    else $error("event level");
  a_ioc_zero: assert property (p_ioc_zero)
    else $error("spare bits");
  a_oe: assert property (p_oe)
    else $error("port enable");
  a_port: assert property (p_port)
    else $error("port level");
  a_fast: assert property (p_fast)
    else $error("fast source");
  a_wake_lp: assert property (p_wake_lp)
    else $error("wake mode");
  a_wake_src: assert property (p_wake_src)
    else $error("wake cause");
  a_wake_one: assert property (p_wake_one)
    else $error("wake width");
  a_ioc_od: assert property (p_ioc_od)
    else $error("open drain level");
  a_norm_lvl: assert property (p_norm_lvl)
    else $error("normal level request");
  a_fast_only: assert property (p_fast_only)
    else $error("fast only request");
endmodule
bind eiei_top eiei_props chk_u (.core_clk_i, .rst_n_i, .pins_i,
  .general_port_bits_i, .port_drive_i, .low_power_i,
  .general_port_bits_oe_n_o, .port_level_o, .io_control_register_o,
  .normal_irq_o, .fast_interrupt_request_o, .wake_o);

/* eiei_periph.sv */
// Peripheral-side pin model with pulled-up port wires
`timescale 1ns/1ps
module eiei_periph (
  input  wire logic                        core_clk_i,
  input  wire logic [eiei_pkg::PORT_W-1:0] oe_n_i,
  output eiei_pkg::eiei_pins_t             pins_o,
  output logic [eiei_pkg::PORT_W-1:0]      port_o
);
  logic [eiei_pkg::PORT_W-1:0] ext_q = 8'hff;
  initial pins_o = 17'h166f0;
  // Pull-up: low when either side pulls down
  assign port_o = oe_n_i & ext_q;
  task drive(input logic [16:0] v, input logic [7:0] p = 8'hff);
    @(negedge core_clk_i);
    pins_o = v;
    ext_q = p;
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the interrupt input stage
`timescale 1ns/1ps
module tb_top;
  localparam logic [16:0] IDLE = 17'h166f0;
  localparam logic [16:0] MSK [11] = '{17'h4000, 17'h2000, 17'h1000,
    17'h0100, 17'h0800, 17'h0800, 17'h0400, 17'h0400, 17'h0200, 17'h0200,
    17'h0030};
  localparam logic [2:0] RT [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h0,
    3'h2, 3'h0, 3'h1, 3'h0, 3'h0};
  localparam logic [1:0] EX [11] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2,
    2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
  logic core_clk_i = 1'h0, rst_n_i = 1'h0, ecl = 1'h0, rcl = 1'h0, lp = 1'h0;
  logic [7:0] drv = 8'hff, en = 8'h00, oe, lvl, ioc;
  logic nrm, fst, wk;
  eiei_pkg::eiei_route_t route = '0;
  wire eiei_pkg::eiei_pins_t pins;
  wire [7:0] port;
  int num_errors = 0, check_count = 0;
  eiei_periph per_u (.core_clk_i, .oe_n_i(oe), .pins_o(pins), .port_o(port));
  eiei_top dut_u (.core_clk_i, .rst_n_i, .pins_i(pins), .route_i(route),
    .general_port_bits_i(port), .port_drive_i(drv), .port_irq_en_i(en),
    .edge_one_clr_i(ecl), .rise_clr_i(rcl), .low_power_i(lp),
    .general_port_bits_oe_n_o(oe), .port_level_o(lvl),
    .io_control_register_o(ioc), .normal_irq_o(nrm),
    .fast_interrupt_request_o(fst), .wake_o(wk));
  initial forever #25 core_clk_i = ~core_clk_i;
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Counts wake pulses, so a stuck or doubled pulse shows up
  task wcount(input int n, output logic [7:0] c);
    c = 8'h00;
    repeat (n) begin
      cyc(1);
      c = c + {7'h00, wk};
    end
  endtask
  task t_edge;
    per_u.drive(IDLE ^ 17'h10000);
    cyc(6);
    chk("fall req", 8'h01, nrm);
    chk("fall lvl", 8'h00, ioc[0]);
    ecl = 1;
    cyc(2);
    ecl = 0;
    cyc(3);
    chk("low held", 8'h00, nrm);
    per_u.drive(IDLE);
    cyc(5);
    chk("rise lvl", 8'h01, ioc[0]);
    per_u.drive(IDLE ^ 17'h08000);
    cyc(6);
    per_u.drive(IDLE);
    cyc(3);
    chk("rise req", 8'h01, nrm);
    rcl = 1;
    cyc(2);
    rcl = 0;
    cyc(3);
    chk("rise clr", 8'h00, nrm);
  endtask
  task t_lvl;
    for (int i = 0; i < 11; i++) begin
      per_u.drive(IDLE ^ MSK[i]);
      route = RT[i];
      cyc(5);
      chk("nrm fst", EX[i], {nrm, fst});
      per_u.drive(IDLE);
      cyc(5);
    end
  endtask
  task t_wake;
    logic [7:0] w;
    per_u.drive(IDLE ^ 17'h00080);
    wcount(6, w);
    chk("wake off", 8'h00, w);
    per_u.drive(IDLE);
    lp = 1;
    cyc(4);
    per_u.drive(IDLE ^ 17'h00040);
    wcount(6, w);
    chk("wake", 8'h01, w);
    lp = 0;
    per_u.drive(IDLE);
    cyc(4);
  endtask
  task t_port;
    en = 8'h08;
    per_u.drive(IDLE, 8'hf7);
    cyc(5);
    chk("port irq", 8'h01, nrm);
    chk("port lvl", 8'hf7, lvl);
    en = 8'h00;
    drv = 8'hdf;
    cyc(5);
    chk("masked", 8'h00, nrm);
    chk("oe", 8'hdf, oe);
    chk("pull low", 8'hd7, lvl);
    drv = 8'hff;
    per_u.drive(IDLE);
    cyc(4);
  endtask
  task close_out;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc(2);
    rst_n_i = 1;
    cyc(2);
    t_edge;
    t_lvl;
    t_wake;
    t_port;
    close_out;
  end
  // Far beyond the few hundred cycles the tests take
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
endmodule
